// File: hw/cmf_cfg.svh
// Constants of the gated clock fanout: counts and reset values.
// Assumes inclusion by bare name from the package and the design.
`ifndef CMF_CFG_SVH
`define CMF_CFG_SVH

`define CMF_NUM_OUTPUTS    12
`define CMF_SEL_PRIMARY    1'h0
`define CMF_SEL_TEST       1'h1
`define CMF_RST_GATE       1'h1
`define CMF_RST_DRIVE      1'h1
`define CMF_RST_LEVEL      1'h0

`endif

// File: hw/cmf_fanout.sv
// Two-input clock selector with glitch-free gate and twelve-way fanout.
// Assumes all inputs are synchronous to SYS_CLK and far slower than it.
// Assumes pads outside turn a low output enable into high impedance.
//
// Behaviour
// - Select 0 routes the primary pair, select 1 the test clock.
// - Gate enable is sampled on each falling edge of the selected clock.
// - Sampled gate low holds every output low; drive enable still decides if it floats.
// - Sampled gate high makes every output copy the selected clock.
// - Gated state changes only in the clock low phase, no runt pulses.
// - Drive enable high drives outputs; low floats them all.
// - Twelve outputs, all carrying the same gated clock.

`include "cmf_cfg.svh"

module cmf_fanout #(
  parameter int N_OUT = `CMF_NUM_OUTPUTS
) (
  input  wire logic               SYS_CLK,
  input  wire logic               NRST,
  input  wire logic               CE,
  input  wire cmf_pkg::cmf_diff_t PRIMARY_CLK,
  input  wire logic               SINGLE_ENDED_TEST_CLOCK,
  input  wire cmf_pkg::cmf_ctrl_t CTRL,
  output logic [N_OUT-1:0]        Q_OUT,
  output logic [N_OUT-1:0]        Q_OE
);
  import cmf_pkg::*;

  logic             primary_lvl;
  logic             sel_clk;
  logic             prev_clk_reg;
  logic             fall;
  logic             gate_reg;
  logic             gate_next;
  logic             out_reg;
  logic             drive_reg;

  // Level of the differential pair: true side high, inverted side low
  function automatic logic pair_level(input cmf_diff_t pair);
    pair_level = pair.pos & ~pair.neg;
  endfunction

  // Replicate one bit onto every output lane
  function automatic logic [N_OUT-1:0] fan(input logic bit_in);
    fan = {N_OUT{bit_in}};
  endfunction

  // Pair reads high only when true side is above the inverted side
  assign primary_lvl = pair_level(PRIMARY_CLK);

  // Input selection; pullups make an open select pick the test clock.
  // Select is not synchronised: switching from a high clock to a low one
  // counts as a falling edge and can cut the old high phase short, so
  // switch with the gate off when a clean hand-over matters.
  assign sel_clk = (CTRL.sel == `CMF_SEL_TEST) ? SINGLE_ENDED_TEST_CLOCK
                                               : primary_lvl;

  // Falling edge of whichever clock is selected now
  assign fall = prev_clk_reg & ~sel_clk;

  // Previous level resets low, so reset can never fake a falling edge
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      prev_clk_reg <= `CMF_RST_LEVEL;
    end else if (CE) begin
      prev_clk_reg <= sel_clk;
    end
  end

  // Gate is latched only at a falling edge, when the clock is already low
  assign gate_next = fall ? CTRL.gate_en : gate_reg;

  // Sampled gate resets high, as an open enable pin would read
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      gate_reg <= `CMF_RST_GATE;
    end else if (CE) begin
      gate_reg <= gate_next;
    end
  end

  // One flop feeds all outputs so the copies cannot skew apart
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      out_reg <= `CMF_RST_LEVEL;
    end else if (CE) begin
      out_reg <= sel_clk & gate_next;
    end
  end

  // Drive enable is registered to keep outputs flop-driven;
  // the cost is one cycle of latency from pin to float
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      drive_reg <= `CMF_RST_DRIVE;
    end else if (CE) begin
      drive_reg <= CTRL.drive_en;
    end
  end

  // Fanout; the pad turns a low enable into high impedance
  assign Q_OUT = fan(out_reg);
  assign Q_OE  = fan(drive_reg);

  // All checks run on the system clock; all but the reset check sleep through reset
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // Test clock reaches the pins one cycle after it is sampled
  test_route_a : assert property (
    (CE && gate_next && CTRL.sel == `CMF_SEL_TEST)
      |=> Q_OUT[0] == $past(SINGLE_ENDED_TEST_CLOCK))
    else $error("test clock not routed");

  // Same path for the differential pair when select is low
  primary_route_a : assert property (
    (CE && gate_next && CTRL.sel == `CMF_SEL_PRIMARY)
      |=> Q_OUT[0] == pair_level($past(PRIMARY_CLK)))
    else $error("primary clock not routed");

  // Gate enable is taken at a falling edge of the selected clock
  gate_sample_a : assert property (
    (CE && prev_clk_reg && !sel_clk) |=> gate_reg == $past(CTRL.gate_en))
    else $error("gate enable not sampled at falling edge");

  // Low request at a falling edge stops the outputs at once
  gate_stop_a : assert property (
    (CE && fall && !CTRL.gate_en) |=> !gate_reg && Q_OUT == '0)
    else $error("gate not stopped at falling edge");

  // High request at a falling edge arms the outputs
  gate_start_a : assert property (
    (CE && fall && CTRL.gate_en) |=> gate_reg)
    else $error("gate not armed at falling edge");

  // Between falling edges the sampled gate holds
  gate_keep_a : assert property (
    (CE && !fall) |=> $stable(gate_reg))
    else $error("gate changed away from falling edge");

  // Edge detector follows the selected clock
  edge_track_a : assert property (
    CE |=> prev_clk_reg == $past(sel_clk))
    else $error("edge detector lost the clock");

  // Stopped gate keeps every output low
  gated_low_a : assert property (
    (CE && !gate_reg && !fall)
      |=> Q_OUT == '0 && Q_OE == fan($past(CTRL.drive_en)))
    else $error("gated output not held low");

  // A high output always has an open gate behind it
  high_needs_gate_a : assert property (
    Q_OUT[0] |-> gate_reg)
    else $error("output high with gate closed");

  // Open gate makes the output copy the clock
  clock_copy_a : assert property (
    (CE && gate_reg && !fall) ##1 (CE && gate_reg && !fall)
      |=> Q_OUT[0] == $past(sel_clk))
    else $error("enabled output does not follow clock");

  // High clock with open gate drives every lane high
  full_copy_a : assert property (
    (CE && gate_next && sel_clk) |=> Q_OUT == fan(1'b1))
    else $error("enabled output missed a high phase");

  // Gate may only change while the selected clock is low
  no_runt_a : assert property (
    (CE && gate_reg != gate_next) |-> !sel_clk ##1 Q_OUT[0] == 1'b0)
    else $error("gate changed while clock high");

  // Low clock phase never shows up as a high output
  low_phase_a : assert property (
    (CE && !sel_clk) |=> Q_OUT == '0)
    else $error("output high in clock low phase");

  // Output is low whenever the gate has just changed
  gate_edge_a : assert property (
    $changed(gate_reg) |-> Q_OUT == '0)
    else $error("gate changed under a high output");

  // Output never starts in the cycle its gate opens
  out_rise_a : assert property (
    $rose(Q_OUT[0]) |-> gate_reg && $past(gate_reg))
    else $error("output started with the gate");

  // Drive enable reaches the enables one cycle later
  drive_follow_a : assert property (
    CE |=> Q_OE == fan($past(CTRL.drive_en)))
    else $error("drive enable not followed");

  // Low drive enable floats every lane
  drive_off_a : assert property (
    (CE && !CTRL.drive_en) |=> Q_OE == '0)
    else $error("outputs not floated");

  // High drive enable drives every lane
  drive_on_a : assert property (
    (CE && CTRL.drive_en) |=> Q_OE == fan(1'b1))
    else $error("outputs not driven");

  // Twelve lanes stay identical
  same_copies_a : assert property (
    Q_OUT == fan(Q_OUT[0]) && Q_OE == fan(Q_OE[0]))
    else $error("outputs differ");

  // Clock enable low freezes the pins
  freeze_out_a : assert property (
    !CE |=> $stable(Q_OUT) && $stable(Q_OE))
    else $error("outputs moved while frozen");

  // Clock enable low freezes the gate and the edge detector
  freeze_gate_a : assert property (
    !CE |=> $stable(gate_reg) && $stable(prev_clk_reg))
    else $error("internal state moved while frozen");

  // Reset leaves the pullup defaults: gate on, driven, output low
  reset_default_a : assert property (
    disable iff (1'b0) !NRST |=> gate_reg && Q_OE == fan(1'b1) && Q_OUT == '0)
    else $error("reset defaults wrong");

endmodule // cmf_fanout

// File: hw/cmf_pkg.sv
// Types shared by the gated clock fanout.
// Assumes cmf_cfg.svh is on the include path.
`include "cmf_cfg.svh"

package cmf_pkg;

  // Control pins that travel together into the block
  typedef struct packed {
    logic sel;       // 0 primary pair, 1 single-ended test clock
    logic gate_en;   // Output gate request, sampled on falling edge
    logic drive_en;  // Output drive enable
  } cmf_ctrl_t;

  // Differential primary pair
  typedef struct packed {
    logic pos;
    logic neg;
  } cmf_diff_t;

endpackage

// File: testbench/cmf_src.sv
// Upstream clock sources: primary pair and test clock.
// Assumes a free-running SYS_CLK; both rates are derived from it.
module cmf_src import cmf_pkg::*; (
  input  wire logic SYS_CLK,
  output cmf_diff_t PRIM,
  output logic      TCLK
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // One process owns both clocks; edges land just after SYS_CLK,
  // half periods 3 and 4 so each phase is sampled at least twice
  initial begin
    PRIM = 2'h1;
    TCLK = 1'h0;
    forever begin
      @(posedge SYS_CLK);
      #1 n++;
      if (n % 3 == 0) PRIM = {~PRIM.pos, PRIM.pos};
      if (n % 4 == 0) TCLK = ~TCLK;
    end
  end
endmodule // cmf_src

// File: testbench/test_clock_mux_gated_fanout.sv
// Self-checking bench for the gated clock fanout.
// Assumes cmf_pkg, cmf_fanout and cmf_src compiled first.
module test_clock_mux_gated_fanout;
  timeunit 1ns;
  timeprecision 1ns;
  import cmf_pkg::*;
  logic clk = 0, nrst = 0, ce = 1, tclk, cur, prev, gate, eq, eo;
  cmf_ctrl_t ctrl = 3'h7; // Open pins read high
  cmf_diff_t prim;
  logic [11:0] q_out, q_oe;
  int failures = 0, num_checks = 0, cycles = 0;
  cmf_src src (.SYS_CLK(clk), .PRIM(prim), .TCLK(tclk));
  cmf_fanout DUT (.SYS_CLK(clk), .NRST(nrst), .CE(ce), .PRIMARY_CLK(prim),
    .SINGLE_ENDED_TEST_CLOCK(tclk), .CTRL(ctrl), .Q_OUT(q_out), .Q_OE(q_oe));
  initial forever #5 clk = ~clk;
  // Reference model; a hang ends at the ceiling
  always @(posedge clk) begin
    cur = ctrl.sel ? tclk : prim.pos & ~prim.neg;
    if (!nrst) {prev, gate, eq, eo} = 4'h5;
    else if (ce) begin
      if (prev && !cur) gate = ctrl.gate_en;
      eq = cur & gate;
      eo = ctrl.drive_en;
      prev = cur;
    end
    cycles++;
    if (cycles == 1000) begin
      failures++;
      give_verdict();
    end
  end
  task check(input logic [11:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Drives controls just after the edge, checks each cycle
  task apply(input logic [2:0] v, input logic c, input int n);
    @(posedge clk);
    #1 ctrl = v;
    ce = c;
    repeat (n) begin
      @(negedge clk);
      check(q_out, {12{eq}});
      check(q_oe, {12{eo}});
    end
  endtask
  task t_select;
    apply(3'h3, 1, 40);
    apply(3'h7, 1, 40);
    $display("test select done");
  endtask
  task t_gate;
    apply(3'h5, 1, 30);
    apply(3'h7, 1, 7);
    apply(3'h1, 1, 5);
    apply(3'h3, 1, 30);
    $display("test gate done");
  endtask
  task t_drive_hold;
    apply(3'h6, 1, 12);
    apply(3'h2, 0, 10);
    apply(3'h7, 1, 12);
    $display("test drive and hold done");
  endtask
  // Mid-run reset with the gate off must bring the defaults back
  task t_reset;
    apply(3'h1, 1, 20);
    @(posedge clk);
    #1 nrst = 0;
    @(posedge clk);
    repeat (2) begin
      @(negedge clk);
      check(q_out, 12'h000);
      check(q_oe, 12'hfff);
    end
    @(posedge clk);
    #1 nrst = 1;
    apply(3'h1, 1, 20);
    $display("test reset done");
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    t_select();
    t_gate();
    t_drive_hold();
    t_reset();
    give_verdict();
  end
endmodule // test_clock_mux_gated_fanout
